// [verilog/jkff_cell.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] - On the active edge the cell holds with no control active, sets with only J, clears with only K, and toggles with both.
// [R2] - The K input may be built active low so that tying J and K together gives a plain data flip-flop.
// [R3] - An active-low asynchronous preset forces the output high and an active-low asynchronous clear forces it low, without a clock.
// [R4] - The rising-edge build samples its inputs on the rising edge and changes its output only after it.
// [R5] - The falling-edge build samples its inputs on the falling edge and changes its output only after it.
// [R6] - With gating built in, both controls are qualified by a common enable, a multi-input AND, or an AND/OR from several sources.
// [R7] - Edge, control polarity, preset, clear and gating are build-time choices, defaulting to rising edge, active high and no gating.
module jkff_cell
  import jkff_pkg::*;
#(
  parameter logic       CLK_EDGE   = EDGE_RISE,
  parameter logic       J_POL      = POL_HIGH,
  parameter logic       K_POL      = POL_HIGH,
  parameter logic       HAS_PRESET = 1'b1,
  parameter logic       HAS_CLEAR  = 1'b1,
  parameter jkff_gate_e GATE_MODE  = JKFF_GATE_NONE
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic [SRC_W-1:0] j_in,
  input  wire logic [SRC_W-1:0] k_in,
  input  wire logic             jk_en_in,
  input  wire logic             preset_n_in,
  input  wire logic             clear_n_in,
  output logic                  q_out,
  output logic                  q_n_out
);

  logic j_act;
  logic k_act;
  logic pre_act;
  logic clr_act;
  logic force_any;
  logic q_ff;
  logic nxt_q;
  logic act_clk;
  logic q_mid_ff;

  // Control input qualification, one gate per control
  jkff_gate #(
    .GATE_MODE (GATE_MODE),
    .ACT_LOW   (J_POL)
  ) u_gate_j (
    .src_in  (j_in),
    .en_in   (jk_en_in),
    .act_out (j_act)
  ); // [R6] [R7]

  jkff_gate #(
    .GATE_MODE (GATE_MODE),
    .ACT_LOW   (K_POL)
  ) u_gate_k (
    .src_in  (k_in),
    .en_in   (jk_en_in),
    .act_out (k_act)
  ); // [R2] [R6] [R7]

  // Asynchronous overrides, present only when built in
  assign pre_act   = HAS_PRESET & ~preset_n_in; // [R3]
  assign clr_act   = HAS_CLEAR & ~clear_n_in;   // [R3]
  assign force_any = pre_act | clr_act;

  // Clock as seen by the storage, for checks
  assign act_clk = (CLK_EDGE == EDGE_FALL) ? ~clk_in : clk_in;

  // Next state from the control table, frozen while ce is low
  always_comb begin
    nxt_q = q_ff;
    if (ce_in) begin
      case ({j_act, k_act})
        2'b00:   nxt_q = q_ff;     // [R1] Hold
        2'b10:   nxt_q = 1'b1;     // [R1] Set
        2'b01:   nxt_q = 1'b0;     // [R1] Reset
        2'b11:   nxt_q = ~q_ff;    // [R1] Toggle
        default: nxt_q = q_ff;
      endcase
    end
  end

  // Storage on the chosen edge; clear beats preset when both are low
  generate
    if (CLK_EDGE == EDGE_FALL) begin : g_fall
      always_ff @(negedge clk_in or posedge rst_in or negedge preset_n_in
                  or negedge clear_n_in) begin
        if (rst_in) begin
          q_ff <= Q_RESET;
        end else if (HAS_CLEAR && !clear_n_in) begin
          q_ff <= Q_CLEAR;         // [R3]
        end else if (HAS_PRESET && !preset_n_in) begin
          q_ff <= Q_PRESET;        // [R3]
        end else begin
          q_ff <= nxt_q;           // [R5]
        end
      end
    end else begin : g_rise
      always_ff @(posedge clk_in or posedge rst_in or negedge preset_n_in
                  or negedge clear_n_in) begin
        if (rst_in) begin
          q_ff <= Q_RESET;
        end else if (HAS_CLEAR && !clear_n_in) begin
          q_ff <= Q_CLEAR;         // [R3]
        end else if (HAS_PRESET && !preset_n_in) begin
          q_ff <= Q_PRESET;        // [R3]
        end else begin
          q_ff <= nxt_q;           // [R4]
        end
      end
    end
  endgenerate

  // True and complement outputs straight from storage
  assign q_out   = q_ff;
  assign q_n_out = ~q_ff;

  // Checks on the control table, data mode and asynchronous overrides
  property p_hold;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (ce_in && !j_act && !k_act) |=> (q_out == $past(q_out));
  endproperty
  a_hold: assert property (p_hold) // [R1]
    else $error("Output moved while holding");

  property p_set;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (ce_in && j_act && !k_act) |=> (q_out && (q_n_out == 1'b0));
  endproperty
  a_set: assert property (p_set) // [R1]
    else $error("Set did not drive output high");

  property p_reset;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (ce_in && !j_act && k_act) |=> !q_out;
  endproperty
  a_reset: assert property (p_reset) // [R1]
    else $error("Reset did not drive output low");

  property p_toggle;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (ce_in && j_act && k_act) |=> (q_out != $past(q_out));
  endproperty
  a_toggle: assert property (p_toggle) // [R1]
    else $error("Toggle did not invert output");

  property p_data_mode;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (K_POL == POL_LOW && J_POL == POL_HIGH && GATE_MODE == JKFF_GATE_NONE
       && ce_in && (j_in[0] == k_in[0])) |=> (q_out == $past(j_in[0]));
  endproperty
  a_data_mode: assert property (p_data_mode) // [R2]
    else $error("Tied J and inverted K did not capture data");

  property p_clear;
    @(posedge act_clk) disable iff (rst_in)
      clr_act |-> (q_out == Q_CLEAR) && (q_n_out != Q_CLEAR);
  endproperty
  a_clear: assert property (p_clear) // [R3]
    else $error("Clear did not hold output low");

  property p_preset;
    @(posedge act_clk) disable iff (rst_in)
      (pre_act && !clr_act) |-> (q_out == Q_PRESET);
  endproperty
  a_preset: assert property (p_preset) // [R3]
    else $error("Preset did not hold output high");

  // Output as seen at the inactive edge, for the quiet-edge check
  always_ff @(negedge act_clk or posedge rst_in) begin
    if (rst_in) begin
      q_mid_ff <= Q_RESET;
    end else begin
      q_mid_ff <= q_out;
    end
  end

  property p_quiet_edge;
    @(posedge act_clk) disable iff (rst_in || force_any)
      1'b1 |-> (q_out == q_mid_ff);
  endproperty
  a_quiet_edge: assert property (p_quiet_edge) // [R4] [R5]
    else $error("Output changed on the inactive clock edge");

  property p_freeze;
    @(posedge act_clk) disable iff (rst_in || force_any)
      !ce_in |=> $stable(q_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Output moved with clock enable low");

  property p_gate_enable;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (GATE_MODE == JKFF_GATE_ENABLE && !jk_en_in) |=> $stable(q_out);
  endproperty
  a_gate_enable: assert property (p_gate_enable) // [R6]
    else $error("Output moved with control enable off");

  property p_default_table;
    @(posedge act_clk) disable iff (rst_in || force_any)
      (J_POL == POL_HIGH && K_POL == POL_HIGH && GATE_MODE == JKFF_GATE_NONE
       && ce_in && j_in[0] && !k_in[0]) |=> q_out;
  endproperty
  a_default_table: assert property (p_default_table) // [R7]
    else $error("Default build did not treat J as active high set");

endmodule
`default_nettype wire

// [verilog/jkff_pkg.sv]
`default_nettype none
package jkff_pkg;

  // Active clock edge choice
  localparam logic EDGE_RISE = 1'b0;
  localparam logic EDGE_FALL = 1'b1;

  // Control input polarity choice
  localparam logic POL_HIGH = 1'b0;
  localparam logic POL_LOW  = 1'b1;

  // Number of source lines per control input
  localparam int unsigned SRC_W = 4;

  // Output value after reset and under clear / preset
  localparam logic Q_RESET  = 1'b0;
  localparam logic Q_CLEAR  = 1'b0;
  localparam logic Q_PRESET = 1'b1;

  // Control input qualification modes
  typedef enum {
    JKFF_GATE_NONE,
    JKFF_GATE_ENABLE,
    JKFF_GATE_AND,
    JKFF_GATE_ANDOR
  } jkff_gate_e;

endpackage
`default_nettype wire

// [verilog/jkff_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module jkff_gate
  import jkff_pkg::*;
#(
  parameter jkff_gate_e GATE_MODE = JKFF_GATE_NONE,
  parameter logic       ACT_LOW   = POL_HIGH
) (
  input  wire logic [SRC_W-1:0] src_in,
  input  wire logic             en_in,
  output logic                  act_out
);

  logic [SRC_W-1:0] lvl;

  // Bring every source line to active-high sense
  assign lvl = ACT_LOW ? ~src_in : src_in;

  // Qualify or combine the sources
  always_comb begin
    case (GATE_MODE)
      JKFF_GATE_NONE:   act_out = lvl[0];
      JKFF_GATE_ENABLE: act_out = lvl[0] & en_in;
      JKFF_GATE_AND:    act_out = &lvl;
      JKFF_GATE_ANDOR:  act_out = (lvl[0] & lvl[1]) | (lvl[2] & lvl[3]);
      default:          act_out = lvl[0];
    endcase
  end

endmodule
`default_nettype wire

// [test/jkff_glue.sv]
`timescale 1ns/1ps
`default_nettype none
module jkff_glue
  import jkff_pkg::*;
(
  input  wire logic [1:0]       op_in,
  output logic      [SRC_W-1:0] j_out,
  output logic      [SRC_W-1:0] k_out
);
  // Glue fans the chosen J/K pair onto every source line
  assign j_out = {SRC_W{op_in[1]}};
  assign k_out = {SRC_W{op_in[0]}};
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import jkff_pkg::*;
  logic             clk_in      = 1'b0;
  logic             rst_in      = 1'b1;
  logic             ce_in       = 1'b0;
  logic             preset_n_in = 1'b1;
  logic             clear_n_in  = 1'b1;
  logic [1:0]       op          = 2'h0;
  logic [SRC_W-1:0] j_w;
  logic [SRC_W-1:0] k_w;
  logic             q_out;
  logic             q_n_out;
  logic             exp_q       = 1'b0;
  logic             q_d;
  logic             exp_d       = 1'b0;
  int               err_total   = 0;
  int               num_checks  = 0;

  // Clock, 5 ns period
  always #2.5 clk_in = ~clk_in;

  jkff_glue glue_u (.op_in(op), .j_out(j_w), .k_out(k_w));
  jkff_cell dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .j_in(j_w), .k_in(k_w),
    .jk_en_in(1'b1), .preset_n_in(preset_n_in), .clear_n_in(clear_n_in),
    .q_out(q_out), .q_n_out(q_n_out));
  // Falling-edge data-flop build: J and K tied together, K active low
  jkff_cell #(.CLK_EDGE(EDGE_FALL), .K_POL(POL_LOW)) dut_d (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .j_in(j_w), .k_in(j_w), .jk_en_in(1'b1), .preset_n_in(1'b1),
    .clear_n_in(1'b1), .q_out(q_d), .q_n_out());

  // Compare both outputs against the expected state
  task automatic chk(input logic e);
    num_checks++;
    if (!(q_out === e && q_n_out === ~e)) begin
      err_total++;
      $display("unexpected t=%0t q=%h exp=%h", $time, q_out, e);
    end
  endtask

  // One control pair taken at an edge, then back to hold
  task automatic step(input logic j, input logic k);
    @(posedge clk_in);
    op <= {j, k};
    @(posedge clk_in);
    op <= 2'h0;
    #1;
    if (ce_in) exp_q = (j & k) ? ~exp_q : j ? 1'b1 : k ? 1'b0 : exp_q;
    chk(exp_q);
    exp_d = ce_in ? j : 1'b0;
    num_checks++;
    if (q_d !== exp_d) begin
      err_total++;
      $display("unexpected t=%0t qd=%h exp=%h", $time, q_d, exp_d);
    end
  endtask

  // Every J/K code, back to back, including double toggle
  task automatic t_ops();
    logic [1:0] seq [10] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h3, 2'h1, 2'h1, 2'h3, 2'h2, 2'h3};
    foreach (seq[i]) step(seq[i][1], seq[i][0]);
    $display("test ops done");
  endtask

  // Clock enable low freezes the state
  task automatic t_ce();
    @(posedge clk_in);
    ce_in <= 1'b0;
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    @(posedge clk_in);
    ce_in <= 1'b1;
    $display("test ce done");
  endtask

  // Preset and clear act without a clock, clear wins
  task automatic t_async();
    step(1'b1, 1'b0);
    @(negedge clk_in);
    clear_n_in <= 1'b0;
    #1 chk(1'b0);
    @(negedge clk_in);
    clear_n_in  <= 1'b1;
    preset_n_in <= 1'b0;
    #1 chk(1'b1);
    @(posedge clk_in);
    clear_n_in <= 1'b0;
    #1 chk(1'b0);
    @(posedge clk_in);
    clear_n_in  <= 1'b1;
    preset_n_in <= 1'b1;
    exp_q = 1'b0;
    step(1'b0, 1'b0);
    $display("test async done");
  endtask

  // Reset in mid-run clears the state, then toggling resumes
  task automatic t_rst();
    step(1'b1, 1'b0);
    @(negedge clk_in);
    rst_in <= 1'b1;
    #1 chk(1'b0);
    @(posedge clk_in);
    rst_in <= 1'b0;
    exp_q = 1'b0;
    step(1'b1, 1'b1);
    $display("test reset done");
  endtask

  // Counts and verdict, then stop
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    ce_in  <= 1'b1;
    chk(1'b0);
    t_ops();
    t_ce();
    t_async();
    t_rst();
    test_done();
  end

  // Watchdog, well beyond the expected 44 cycles
  initial begin
    #2000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
